// ---- rtl/anma_pkg.sv ----
// Constants and types shared by the nonvolatile memory host controller
package anma_pkg;

  // ----------------------------------------------------------------
  // Geometry and clock
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 16;
  localparam int COL_W = 2;
  localparam int SYNC_STAGES = 2;
  localparam int CNT_W = 8;
  localparam int STEP_W = 4;

  // ----------------------------------------------------------------
  // Timing, in ns as given, then derived cycle counts
  // ----------------------------------------------------------------
  localparam int ADDRESS_SETUP_TIME_NS = 10;
  localparam int ACCESS_TIME_NS = 70;
  localparam int PRECHARGE_TIME_NS = 60;

  // Least times round up, never below one cycle
  function automatic logic [CNT_W-1:0] ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1)
    begin
      c = 1;
    end
    return CNT_W'(c);
  endfunction

  localparam logic [CNT_W-1:0] SETUP_CYC = ns_to_cyc(ADDRESS_SETUP_TIME_NS);
  localparam logic [CNT_W-1:0] WR_CYC = ns_to_cyc(ACCESS_TIME_NS);
  // Reads also wait out the two-stage pin synchroniser plus margin
  localparam logic [CNT_W-1:0] RD_CYC = CNT_W'(ns_to_cyc(ACCESS_TIME_NS) + SYNC_STAGES + 1);
  localparam logic [CNT_W-1:0] PC_CYC = ns_to_cyc(PRECHARGE_TIME_NS);
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

  // ----------------------------------------------------------------
  // Protection-change sequence
  // ----------------------------------------------------------------
  localparam logic [STEP_W-1:0] WP_FIRST_STEP = 4'h0;
  localparam logic [STEP_W-1:0] WP_BYTE_STEP = 4'h6;
  localparam logic [STEP_W-1:0] WP_COMPL_STEP = 4'h7;
  localparam logic [STEP_W-1:0] WP_DUMMY_STEP = 4'h8;
  localparam logic [STEP_W-1:0] WP_LAST_STEP = 4'h9;
  localparam logic [ADDR_W-1:0] WP_ADDR_0 = 17'h12555;
  localparam logic [ADDR_W-1:0] WP_ADDR_1 = 17'h1daaa;
  localparam logic [ADDR_W-1:0] WP_ADDR_2 = 17'h01333;
  localparam logic [ADDR_W-1:0] WP_ADDR_3 = 17'h0eccc;
  localparam logic [ADDR_W-1:0] WP_ADDR_4 = 17'h000ff;
  localparam logic [ADDR_W-1:0] WP_ADDR_5 = 17'h1ff00;
  localparam logic [ADDR_W-1:0] WP_ADDR_6 = 17'h1daaa;
  localparam logic [ADDR_W-1:0] WP_ADDR_7 = 17'h0eccc;
  localparam logic [ADDR_W-1:0] WP_ADDR_8 = 17'h0ff00;
  localparam logic [ADDR_W-1:0] WP_ADDR_9 = 17'h00000;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_ACCESS,
    ST_WEND,
    ST_DONE,
    ST_OPEN,
    ST_PRE
  } anma_state_type;

endpackage

// ---- rtl/anma_wp_step.sv ----
// Address, direction and data of each step of the protection-change sequence
`timescale 1ns/100ps
module anma_wp_step
  import anma_pkg::*;
(
  input wire logic [STEP_W-1:0] step,
  input wire logic [7:0] prot_byte,
  output logic [ADDR_W-1:0] step_addr,
  output logic step_write,
  output logic [DATA_W-1:0] step_data
);

  always_comb
  begin
    step_write = 1'h0;
    step_data = 16'h0000;
    step_addr = WP_ADDR_0;
    case (step)
      4'h1: step_addr = WP_ADDR_1;
      4'h2: step_addr = WP_ADDR_2;
      4'h3: step_addr = WP_ADDR_3;
      4'h4: step_addr = WP_ADDR_4;
      4'h5: step_addr = WP_ADDR_5;
      WP_BYTE_STEP:
      begin
        step_addr = WP_ADDR_6;
        step_write = 1'h1;
        step_data = {8'h00, prot_byte};
      end
      WP_COMPL_STEP:
      begin
        step_addr = WP_ADDR_7;
        step_write = 1'h1;
        step_data = {8'h00, ~prot_byte};
      end
      WP_DUMMY_STEP:
      begin
        step_addr = WP_ADDR_8;
        step_write = 1'h1;
      end
      WP_LAST_STEP: step_addr = WP_ADDR_9;
      default: step_addr = WP_ADDR_0;
    endcase
  end

endmodule

// ---- rtl/anma_host.sv ----
// Host-side controller for an asynchronous SRAM-compatible nonvolatile memory
`timescale 1ns/100ps
module anma_host
  import anma_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic req,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic [1:0] req_be,
  input wire logic req_hold,
  output logic ready,
  output logic [DATA_W-1:0] rdata,
  output logic rvalid,
  input wire logic wp_req,
  input wire logic [7:0] wp_byte,
  output logic wp_done,
  output logic mem_ce_n,
  output logic mem_we_n,
  output logic mem_oe_n,
  output logic mem_upper_byte_select_n,
  output logic mem_lower_byte_select_n,
  output logic [ADDR_W-1:0] mem_addr,
  input wire logic [DATA_W-1:0] mem_dq_i,
  output logic [DATA_W-1:0] mem_dq_o,
  output logic mem_dq_oe
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    anma_state_type st;
    logic [CNT_W-1:0] cnt;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic write;
    logic hold;
    logic wp;
    logic [STEP_W-1:0] step;
    logic [7:0] wpb;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic ub_n;
    logic lb_n;
    logic dq_oe;
    logic ready;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic wp_done;
    logic [DATA_W-1:0] sync1;
    logic [DATA_W-1:0] sync2;
  } anma_regs_type;

  localparam anma_regs_type REGS_RESET = '{
    st: ST_IDLE, cnt: 8'h00, addr: 17'h00000, wdata: 16'h0000, write: 1'h0,
    hold: 1'h0, wp: 1'h0, step: 4'h0, wpb: 8'h00, ce_n: 1'h1, we_n: 1'h1,
    oe_n: 1'h1, ub_n: 1'h1, lb_n: 1'h1, dq_oe: 1'h0, ready: 1'h0,
    rdata: 16'h0000, rvalid: 1'h0, wp_done: 1'h0, sync1: 16'h0000, sync2: 16'h0000};

  anma_regs_type s_q;
  anma_regs_type s_d;

  logic [STEP_W-1:0] step_idx;
  logic [ADDR_W-1:0] step_addr;
  logic step_write;
  logic [DATA_W-1:0] step_data;

  function automatic logic same_row(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
    return a[ADDR_W-1:COL_W] == b[ADDR_W-1:COL_W];
  endfunction

  assign step_idx = (s_q.st == ST_IDLE) ? WP_FIRST_STEP : STEP_W'(s_q.step + 4'h1);

  anma_wp_step u_step (
    .step(step_idx),
    .prot_byte(s_q.wpb),
    .step_addr(step_addr),
    .step_write(step_write),
    .step_data(step_data)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.rvalid = 1'h0;
    s_d.wp_done = 1'h0;
    s_d.sync1 = mem_dq_i;
    s_d.sync2 = s_q.sync1;
    case (s_q.st)
      ST_IDLE:
      begin
        if (wp_req && s_q.ready)
        begin
          s_d.wp = 1'h1;
          s_d.hold = 1'h0;
          s_d.wpb = wp_byte;
          s_d.step = WP_FIRST_STEP;
          s_d.addr = step_addr;
          s_d.write = step_write;
          s_d.wdata = step_data;
          s_d.ub_n = 1'h0;
          s_d.lb_n = 1'h0;
          s_d.ready = 1'h0;
          s_d.cnt = SETUP_CYC;
          s_d.st = ST_SETUP;
        end
        else if (req && s_q.ready)
        begin
          s_d.addr = req_addr;
          s_d.write = req_write;
          s_d.wdata = req_wdata;
          s_d.ub_n = ~req_be[1];
          s_d.lb_n = ~req_be[0];
          s_d.hold = req_hold;
          s_d.ready = 1'h0;
          s_d.cnt = SETUP_CYC;
          s_d.st = ST_SETUP;
        end
        else
        begin
          // Idle with nothing taken offers the bus, also right after reset
          s_d.ready = 1'h1;
        end
      end
      ST_SETUP:
      begin
        // Address has stood for the setup time before the strobes move
        if (s_q.cnt == CNT_ONE)
        begin
          s_d.ce_n = 1'h0;
          s_d.we_n = ~s_q.write;
          s_d.oe_n = s_q.write;
          s_d.dq_oe = s_q.write;
          s_d.cnt = s_q.write ? WR_CYC : RD_CYC;
          s_d.st = ST_ACCESS;
        end
        else
        begin
          s_d.cnt = CNT_W'(s_q.cnt - CNT_ONE);
        end
      end
      ST_ACCESS:
      begin
        if (s_q.cnt == CNT_ONE)
        begin
          if (s_q.write)
          begin
            // Data stays driven one cycle past the strobe rise for hold
            s_d.we_n = 1'h1;
            s_d.st = ST_WEND;
          end
          else
          begin
            s_d.oe_n = 1'h1;
            s_d.rdata = s_q.wp ? s_q.rdata : s_q.sync2;
            s_d.rvalid = ~s_q.wp;
            s_d.st = ST_DONE;
          end
        end
        else
        begin
          s_d.cnt = CNT_W'(s_q.cnt - CNT_ONE);
        end
      end
      ST_WEND:
      begin
        s_d.dq_oe = 1'h0;
        s_d.st = ST_DONE;
      end
      ST_DONE:
      begin
        if (s_q.hold && !s_q.wp)
        begin
          s_d.ready = 1'h1;
          s_d.st = ST_OPEN;
        end
        else
        begin
          s_d.ce_n = 1'h1;
          s_d.cnt = PC_CYC;
          s_d.st = ST_PRE;
        end
      end
      ST_OPEN:
      begin
        if (req && same_row(req_addr, s_q.addr))
        begin
          s_d.addr = req_addr;
          s_d.write = req_write;
          s_d.wdata = req_wdata;
          s_d.ub_n = ~req_be[1];
          s_d.lb_n = ~req_be[0];
          s_d.hold = req_hold;
          s_d.ready = 1'h0;
          s_d.cnt = SETUP_CYC;
          s_d.st = ST_SETUP;
        end
        else if (req || !req_hold)
        begin
          // Row change or end of page: close and pre-charge first
          s_d.ce_n = 1'h1;
          s_d.ready = 1'h0;
          s_d.cnt = PC_CYC;
          s_d.st = ST_PRE;
        end
      end
      ST_PRE:
      begin
        if (s_q.cnt != CNT_ONE)
        begin
          s_d.cnt = CNT_W'(s_q.cnt - CNT_ONE);
        end
        else if (s_q.wp && s_q.step != WP_LAST_STEP)
        begin
          s_d.step = step_idx;
          s_d.addr = step_addr;
          s_d.write = step_write;
          s_d.wdata = step_data;
          s_d.cnt = SETUP_CYC;
          s_d.st = ST_SETUP;
        end
        else
        begin
          s_d.wp_done = s_q.wp;
          s_d.wp = 1'h0;
          s_d.ub_n = 1'h1;
          s_d.lb_n = 1'h1;
          s_d.ready = 1'h1;
          s_d.st = ST_IDLE;
        end
      end
      default:
      begin
        s_d = REGS_RESET;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= REGS_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Ready comes up one cycle after reset release, from the idle state
  assign ready = s_q.ready;
  assign rdata = s_q.rdata;
  assign rvalid = s_q.rvalid;
  assign wp_done = s_q.wp_done;
  assign mem_ce_n = s_q.ce_n;
  assign mem_we_n = s_q.we_n;
  assign mem_oe_n = s_q.oe_n;
  assign mem_upper_byte_select_n = s_q.ub_n;
  assign mem_lower_byte_select_n = s_q.lb_n;
  assign mem_addr = s_q.addr;
  assign mem_dq_o = s_q.wdata;
  assign mem_dq_oe = s_q.dq_oe;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  localparam int PC_MIN = int'(PC_CYC);
  localparam int PAGE_MAX = int'(SETUP_CYC) + int'(RD_CYC) + 3;
  logic [CNT_W-1:0] high_cnt_q;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      high_cnt_q <= 8'hff;
    end
    else if (!s_q.ce_n)
    begin
      high_cnt_q <= 8'h00;
    end
    else if (high_cnt_q != 8'hff)
    begin
      high_cnt_q <= CNT_W'(high_cnt_q + CNT_ONE);
    end
  end

  wp_addr_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (s_q.wp && !mem_ce_n) |-> ($stable(mem_addr) && $past(mem_ce_n, 1) == 1'h0 || $fell(mem_ce_n)))
    else $error("Address moved while chip select low in protection sequence");
  wp_addr_setup_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (s_q.wp && $fell(mem_ce_n)) |-> $stable(mem_addr))
    else $error("Address not set up before chip select fell");
  we_inside_ce_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !mem_we_n |-> (!mem_ce_n && !mem_oe_n == 1'h0))
    else $error("Write strobe low outside a chip-selected write");
  wp_data_compl_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (s_q.wp && !mem_we_n && s_q.step == WP_COMPL_STEP)
      |-> (mem_dq_o[7:0] == ~s_q.wpb && mem_addr == WP_ADDR_7 && mem_dq_oe))
    else $error("Protection complement write is wrong");
  wp_data_byte_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (s_q.wp && !mem_we_n && s_q.step == WP_BYTE_STEP)
      |-> (mem_dq_o[7:0] == s_q.wpb && mem_addr == WP_ADDR_6))
    else $error("Protection byte write is wrong");
  ce_idle_high_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (s_q.st == ST_IDLE) |-> mem_ce_n)
    else $error("Chip select low while idle");
  precharge_min_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    $fell(mem_ce_n) |-> ($past(high_cnt_q, 1) >= CNT_W'(PC_MIN - 1)))
    else $error("Chip select high shorter than pre-charge time");
  page_budget_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (s_q.st == ST_OPEN && req && same_row(req_addr, s_q.addr))
      |-> ##[1:PAGE_MAX] (s_q.st == ST_OPEN || s_q.st == ST_PRE))
    else $error("Page access exceeded its cycle budget");

  wp_done_c: cover property (@(posedge clk_sys) disable iff (!rstn) wp_done);
  read_done_c: cover property (@(posedge clk_sys) disable iff (!rstn) rvalid);
  page_reuse_c: cover property (@(posedge clk_sys) disable iff (!rstn)
    (s_q.st == ST_OPEN) ##1 (s_q.st == ST_SETUP && !mem_ce_n));

endmodule

// ---- testbench/anma_mem_model.sv ----
// Behavioural nonvolatile word memory facing the host controller
`timescale 1ns/100ps
module anma_mem_model
  import anma_pkg::*;
(
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic upper_byte_select_n,
  input wire logic lower_byte_select_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_en,
  output int row_opens,
  output int moves,
  output int timing_errs,
  output logic [7:0] prot_q
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] lanes;
  logic [ADDR_W-1:0] seq [0:9];
  logic [ADDR_W-3:0] row_q = '0;
  logic [7:0] pend_q = 8'h00;
  logic wrote_q = 1'b0;
  logic bad_q = 1'b0;
  int step = 0;
  realtime t_rise = 0.0;
  realtime t_addr = 0.0;

  initial
  begin
    seq = '{17'h12555, 17'h1daaa, 17'h01333, 17'h0eccc, 17'h000ff, 17'h1ff00,
      17'h1daaa, 17'h0eccc, 17'h0ff00, 17'h00000};
    row_opens = 0;
    moves = 0;
    timing_errs = 0;
    prot_q = 8'h00;
    for (int i = 0; i < (1 << ADDR_W); i++)
    begin
      mem[i] = DATA_W'(i) ^ 16'h5a5a;
    end
  end

  // ----------------------------------------------------------------
  // Data lines
  // ----------------------------------------------------------------
  // Unselected or released lanes show the inverse, so no stale value passes
  assign lanes = {{8{!upper_byte_select_n}}, {8{!lower_byte_select_n}}};
  assign dq_en = !ce_n && !oe_n && we_n;
  assign dq_out = dq_en ? ((mem[addr] & lanes) | (~mem[addr] & ~lanes)) : ~mem[addr];

  always @(posedge we_n)
  begin
    if (ce_n === 1'b0)
    begin
      wrote_q = 1'b1;
      if (step == 6)
        pend_q = dq_in[7:0];
      if (step == 7 && dq_in[7:0] !== ~pend_q)
        bad_q = 1'b1;
      // Protection byte and its complement never reach the array
      if (step < 6 || step > 7)
        mem[addr] = (dq_in & lanes) | (mem[addr] & ~lanes);
    end
  end

  // ----------------------------------------------------------------
  // Row openings and timing
  // ----------------------------------------------------------------
  always @(negedge ce_n)
  begin
    row_opens++;
    row_q = addr[ADDR_W-1:2];
    if ($realtime - t_rise < PRECHARGE_TIME_NS || $realtime - t_addr < ADDRESS_SETUP_TIME_NS)
      timing_errs++;
  end

  always @(addr)
  begin
    t_addr = $realtime;
    if (ce_n === 1'b0)
    begin
      moves++;
      if (addr[ADDR_W-1:2] != row_q)
      begin
        row_opens++;
        row_q = addr[ADDR_W-1:2];
      end
    end
  end

  // Sequence only advances on whole chip-select cycles
  always @(posedge ce_n)
  begin
    t_rise = $realtime;
    if (addr === seq[step] && wrote_q === (step >= 6 && step <= 8) && !bad_q)
    begin
      if (step == 9)
        prot_q = pend_q;
      step = (step + 1) % 10;
    end
    else
      step = (addr === 17'h12555 && !wrote_q) ? 1 : 0;
    wrote_q = 1'b0;
    bad_q = 1'b0;
  end
endmodule

// ---- testbench/tb_top.sv ----
// Self-checking bench for the nonvolatile memory host controller
`timescale 1ns/100ps
module tb_top
  import anma_pkg::*;
;
  logic clk_sys, rstn, req, req_write, req_hold, ready, rvalid, wp_req, wp_done;
  logic mem_ce_n, mem_we_n, mem_oe_n, mem_upper_byte_select_n, mem_lower_byte_select_n;
  logic mem_dq_oe, dq_en;
  logic [1:0] req_be;
  logic [7:0] wp_byte, prot_q;
  logic [ADDR_W-1:0] req_addr, mem_addr;
  logic [DATA_W-1:0] req_wdata, rdata, mem_dq_i, mem_dq_o, dq_out;
  int row_opens, moves, timing_errs;
  int error_cnt = 0;
  int total_checks = 0;
  logic [15:0] lfsr_q = 16'h4aa4;
  logic [DATA_W-1:0] ref_mem [int];
  logic [ADDR_W-1:0] used [$];

  // A bus nobody drives shows the inverse of the controller's value
  assign mem_dq_i = mem_dq_oe ? mem_dq_o : (dq_en ? dq_out : ~mem_dq_o);

  anma_host DUT (.clk_sys, .rstn, .req, .req_write, .req_addr, .req_wdata, .req_be,
    .req_hold, .ready, .rdata, .rvalid, .wp_req, .wp_byte, .wp_done, .mem_ce_n,
    .mem_we_n, .mem_oe_n, .mem_upper_byte_select_n, .mem_lower_byte_select_n,
    .mem_addr, .mem_dq_i, .mem_dq_o, .mem_dq_oe);

  anma_mem_model u_mem (.ce_n(mem_ce_n), .we_n(mem_we_n), .oe_n(mem_oe_n),
    .upper_byte_select_n(mem_upper_byte_select_n),
    .lower_byte_select_n(mem_lower_byte_select_n), .addr(mem_addr), .dq_in(mem_dq_i),
    .dq_out, .dq_en, .row_opens, .moves, .timing_errs, .prot_q);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  function automatic logic [DATA_W-1:0] ref_rd(input logic [ADDR_W-1:0] a);
    return ref_mem.exists(a) ? ref_mem[a] : (DATA_W'(a) ^ 16'h5a5a);
  endfunction

  function automatic logic flag(input int k);
    return (k == 0) ? ready === 1'b1 : (k == 1) ? rvalid === 1'b1 : wp_done === 1'b1;
  endfunction

  task automatic rnd(output logic [15:0] v);
    lfsr_q = lfsr_next(lfsr_q);
    v = lfsr_q;
  endtask

  task automatic results();
    if (error_cnt == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (!ok)
    begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic wait_for(input int k);
    for (int n = 0; n < 200; n++)
    begin
      @(negedge clk_sys);
      if (flag(k))
        return;
    end
    error_cnt++;
    $display("wrong value at %0t: wait timed out", $time);
    results();
  endtask

  task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [1:0] be,
    input logic hold);
    logic [DATA_W-1:0] d;
    logic [DATA_W-1:0] m;
    rnd(d);
    m = {{8{be[1]}}, {8{be[0]}}};
    wait_for(0);
    @(posedge clk_sys);
    req <= 1'b1;
    req_write <= wr;
    req_addr <= a;
    req_wdata <= d;
    req_be <= be;
    req_hold <= hold;
    @(posedge clk_sys);
    req <= 1'b0;
    if (wr)
      ref_mem[a] = (d & m) | (ref_rd(a) & ~m);
    else
    begin
      wait_for(1);
      check(((rdata ^ ref_rd(a)) & m) === 16'h0000, "read data");
    end
  endtask

  task automatic protect(input logic [7:0] b);
    int m0;
    int r0;
    m0 = moves;
    r0 = row_opens;
    wait_for(0);
    @(posedge clk_sys);
    wp_req <= 1'b1;
    wp_byte <= b;
    @(posedge clk_sys);
    wp_req <= 1'b0;
    wait_for(2);
    check(prot_q === b, "protection byte");
    check(moves === m0, "address moved under chip select");
    check(row_opens - r0 === 10, "step without chip select toggle");
  endtask

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  initial
  begin
    logic [15:0] r;
    logic [ADDR_W-1:0] a;
    int o0;
    int m0;
    {rstn, req, req_write, req_hold, wp_req} = 5'h00;
    {req_be, wp_byte, req_addr, req_wdata} = '0;
    repeat (20) @(posedge clk_sys);
    check(mem_ce_n === 1'b1 && mem_we_n === 1'b1 && ready === 1'b0, "reset state");
    rstn <= 1'b1;
    for (int i = 0; i < 40; i++)
    begin
      rnd(r);
      a = {r[0], r};
      if (r[1] && used.size() > 0)
        a = used[r[6:2] % used.size()];
      else if (r[2])
        used.push_back(a);
      access(!r[1] && r[2], a, r[4:3], 1'b0);
    end
    wait_for(0);
    check(mem_ce_n === 1'b1, "chip select left low");
    rnd(r);
    a = {r[0], r[15:2], 2'b00};
    for (int p = 0; p < 2; p++)
    begin
      o0 = row_opens;
      m0 = moves;
      for (int w = 0; w < 4; w++)
        access(p == 0, a + 17'(3 - w), 2'b11 ^ 2'(w & p), w < 3);
      // Last write's address lands at its take edge, so let it settle
      @(negedge clk_sys);
      check(row_opens - o0 === 1, "row opened more than once");
      check(moves - m0 === 3, "page address changes");
    end
    access(1'b0, a, 2'b11, 1'b1);
    o0 = row_opens;
    wait_for(0);
    @(posedge clk_sys);
    req <= 1'b1;
    req_addr <= a ^ 17'h00010;
    req_hold <= 1'b0;
    @(posedge clk_sys);
    req <= 1'b0;
    @(negedge clk_sys);
    check(ready === 1'b0 && mem_ce_n === 1'b1 && rvalid === 1'b0, "foreign row taken");
    access(1'b0, a ^ 17'h00010, 2'b11, 1'b0);
    check(row_opens - o0 === 1, "new row not opened");
    protect(8'h18);
    rnd(r);
    protect(r[7:0]);
    check(timing_errs === 0, "chip select timing");
    results();
  end
endmodule
